// *** alu_exec.sv ***
// Purpose: execute subtract-with-borrow, swap, xor and direction load
// Assumes: file register write-back handled by caller via file_we/file_wdata
// Notes: one instruction per cycle when req_valid is high
// Notes on behaviour
// - subtract: file minus w minus borrow
// - carry clear means borrow pending
// - dest 0 to w, 1 to file
// - swap nibbles, flags unchanged
// - w to direction reg 5,6,7
// - xor literal into w, zero only
// - xor file, routed by dest
`default_nettype none
module alu_exec (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire alu_pkg::alu_req_type req,
    output logic [7:0] w_reg,
    output alu_pkg::alu_flags_type flags,
    output logic file_we,
    output logic [7:0] file_wdata,
    output logic [7:0] port_a_direction_reg,
    output logic [7:0] port_b_direction_reg,
    output logic [7:0] port_c_direction_reg
);
    logic [7:0] result;              // datapath result
    alu_pkg::alu_flags_type new_flags; // flags from datapath
    logic [7:0] next_w_reg;
    alu_pkg::alu_flags_type next_flags;
    logic next_file_we;
    logic [7:0] next_file_wdata;
    logic [7:0] next_dir_a;
    logic [7:0] next_dir_b;
    logic [7:0] next_dir_c;
    logic has_dest;                  // op uses the destination bit

    // arithmetic and logic
    alu_core u_core (
        .req(req),
        .w_val(w_reg),
        .flags_in(flags),
        .result(result),
        .flags_out(new_flags)
    );

    // next-state selection
    always_comb begin
        next_w_reg = w_reg;
        next_flags = flags;
        next_file_we = 1'b0;
        next_file_wdata = file_wdata;
        next_dir_a = port_a_direction_reg;
        next_dir_b = port_b_direction_reg;
        next_dir_c = port_c_direction_reg;
        // subtract, swap and file xor honour the destination bit
        has_dest = (req.op == alu_pkg::ALU_OP_SUBB) || (req.op == alu_pkg::ALU_OP_SWAP)
                   || (req.op == alu_pkg::ALU_OP_XORF);
        // an idle cycle holds state and drops the write pulse
        if (req_valid) begin
            next_flags = new_flags;
            if (has_dest) begin
                if (req.dest == alu_pkg::ALU_DEST_W) begin
                    next_w_reg = result;
                end else begin
                    next_file_we = 1'b1;
                    next_file_wdata = result;
                end
            end else if (req.op == alu_pkg::ALU_OP_XORI) begin
                next_w_reg = result;
            end else if (req.op == alu_pkg::ALU_OP_DIR) begin
                // operand picks the port, no flag change
                if (req.literal[2:0] == alu_pkg::ALU_DIR_SEL_A) begin
                    next_dir_a = w_reg;
                end else if (req.literal[2:0] == alu_pkg::ALU_DIR_SEL_B) begin
                    next_dir_b = w_reg;
                end else if (req.literal[2:0] == alu_pkg::ALU_DIR_SEL_C) begin
                    next_dir_c = w_reg;
                end
            end
        end
    end

    // registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            w_reg <= alu_pkg::ALU_W_RESET;
            flags <= '0;
            file_we <= 1'b0;
            file_wdata <= 8'h00;
            port_a_direction_reg <= alu_pkg::ALU_DIR_RESET;
            port_b_direction_reg <= alu_pkg::ALU_DIR_RESET;
            port_c_direction_reg <= alu_pkg::ALU_DIR_RESET;
        end else begin
            w_reg <= next_w_reg;
            flags <= next_flags;
            file_we <= next_file_we;
            file_wdata <= next_file_wdata;
            port_a_direction_reg <= next_dir_a;
            port_b_direction_reg <= next_dir_b;
            port_c_direction_reg <= next_dir_c;
        end
    end

    // checks
    subb_result_a: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && req.op == alu_pkg::ALU_OP_SUBB && !req.dest |=>
        w_reg == 8'($past(req.file_val) - $past(w_reg) - {7'h00, ~$past(flags.carry)}))
        else $error("subtract result wrong");
    subb_carry_a: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && req.op == alu_pkg::ALU_OP_SUBB && flags.carry
        && req.file_val >= w_reg |=> flags.carry)
        else $error("carry not set without borrow");
    dest_file_a: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && req.dest && req.op != alu_pkg::ALU_OP_XORI
        && req.op != alu_pkg::ALU_OP_DIR && req.op != alu_pkg::ALU_OP_NONE
        |=> file_we && $stable(w_reg))
        else $error("file destination not honoured");
    swap_flags_a: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && req.op == alu_pkg::ALU_OP_SWAP |=> $stable(flags)
        && (file_we ? file_wdata : w_reg) == {$past(req.file_val[3:0]), $past(req.file_val[7:4])})
        else $error("swap wrong");
    dir_load_a: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && req.op == alu_pkg::ALU_OP_DIR
        && req.literal[2:0] == alu_pkg::ALU_DIR_SEL_B
        |=> port_b_direction_reg == $past(w_reg) && $stable(flags))
        else $error("direction load wrong");
    xori_w_a: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && req.op == alu_pkg::ALU_OP_XORI
        |=> w_reg == ($past(w_reg) ^ $past(req.literal)) && flags.carry == $past(flags.carry))
        else $error("xor literal wrong");
    xorf_carry_a: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && req.op == alu_pkg::ALU_OP_XORF
        |=> $stable(flags.digit_carry_flag) && $stable(flags.carry))
        else $error("xor file touched carries");
    zero_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && req.op == alu_pkg::ALU_OP_XORI && !req.dest
        |=> flags.zero == (w_reg == 8'h00))
        else $error("zero flag wrong");

    // further checks, each looks one edge after the request is taken
    // subtract to the file leaves w alone and pulses the write
    subb_file_a: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && req.op == alu_pkg::ALU_OP_SUBB && req.dest
        |=> file_we && $stable(w_reg)
        && file_wdata == 8'($past(req.file_val) - $past(w_reg) - {7'h00, ~$past(flags.carry)}))
        else $error("subtract file write wrong");

    // zero follows the subtract result
    subb_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && req.op == alu_pkg::ALU_OP_SUBB
        |=> flags.zero
        == (8'($past(req.file_val) - $past(w_reg) - {7'h00, ~$past(flags.carry)}) == 8'h00))
        else $error("subtract zero flag wrong");

    // digit carry is the no-borrow out of the low nibble
    subb_digit_a: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && req.op == alu_pkg::ALU_OP_SUBB
        |=> flags.digit_carry_flag == ({1'b0, $past(req.file_val[3:0])}
        >= {1'b0, $past(w_reg[3:0])} + {4'h0, ~$past(flags.carry)}))
        else $error("digit carry wrong");

    // a pending borrow with f not above w borrows again
    subb_borrow_a: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && req.op == alu_pkg::ALU_OP_SUBB && !flags.carry
        && req.file_val <= w_reg |=> !flags.carry)
        else $error("borrow lost");

    // a w destination never raises the file write
    dest_work_a: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && !req.dest && (req.op == alu_pkg::ALU_OP_SUBB
        || req.op == alu_pkg::ALU_OP_SWAP || req.op == alu_pkg::ALU_OP_XORF)
        |=> !file_we && $stable(file_wdata))
        else $error("w destination wrote the file");

    // port a load leaves the other ports and w alone
    dir_port_a_a: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && req.op == alu_pkg::ALU_OP_DIR
        && req.literal[2:0] == alu_pkg::ALU_DIR_SEL_A
        |=> port_a_direction_reg == $past(w_reg) && $stable(port_b_direction_reg)
        && $stable(port_c_direction_reg) && $stable(w_reg))
        else $error("port a direction load wrong");

    // port c load leaves the other ports alone
    dir_port_c_a: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && req.op == alu_pkg::ALU_OP_DIR
        && req.literal[2:0] == alu_pkg::ALU_DIR_SEL_C
        |=> port_c_direction_reg == $past(w_reg) && $stable(port_a_direction_reg)
        && $stable(port_b_direction_reg) && $stable(flags))
        else $error("port c direction load wrong");

    // selects below port a change nothing at all
    dir_reject_a: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && req.op == alu_pkg::ALU_OP_DIR
        && req.literal[2:0] < alu_pkg::ALU_DIR_SEL_A
        |=> $stable(port_a_direction_reg) && $stable(port_b_direction_reg)
        && $stable(port_c_direction_reg) && $stable(w_reg) && $stable(flags) && !file_we)
        else $error("bad direction select changed state");

    // file xor into w
    xorf_work_a: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && req.op == alu_pkg::ALU_OP_XORF && !req.dest
        |=> w_reg == ($past(w_reg) ^ $past(req.file_val)) && !file_we)
        else $error("xor file to w wrong");

    // file xor back into the file
    xorf_file_a: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && req.op == alu_pkg::ALU_OP_XORF && req.dest
        |=> file_we && $stable(w_reg)
        && file_wdata == ($past(w_reg) ^ $past(req.file_val)))
        else $error("xor file to file wrong");

    // zero follows the file xor result
    xorf_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && req.op == alu_pkg::ALU_OP_XORF
        |=> flags.zero == (($past(w_reg) ^ $past(req.file_val)) == 8'h00))
        else $error("xor file zero flag wrong");

    // literal xor ignores dest and leaves both carries
    xori_nofile_a: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && req.op == alu_pkg::ALU_OP_XORI
        |=> !file_we && $stable(flags.carry) && $stable(flags.digit_carry_flag))
        else $error("xor literal touched file or carries");
endmodule
`default_nettype wire

// *** alu_pkg.sv ***
// Purpose: shared constants and types for the subtract/swap/xor/direction datapath
// Assumes: 8-bit data path, single core clock
// Notes: operation codes are local to this block
`default_nettype none
package alu_pkg;
    localparam int ALU_W = 8;                    // data width
    localparam int ALU_NIB = 4;                  // nibble width
    localparam logic [2:0] ALU_DIR_SEL_A = 3'h5; // port a direction select
    localparam logic [2:0] ALU_DIR_SEL_B = 3'h6; // port b direction select
    localparam logic [2:0] ALU_DIR_SEL_C = 3'h7; // port c direction select
    localparam logic [7:0] ALU_DIR_RESET = 8'hFF; // direction regs reset to input
    localparam logic [7:0] ALU_W_RESET = 8'h00;  // working register reset
    localparam logic ALU_DEST_W = 1'h0;          // destination bit: working reg

    // operation selector
    typedef enum logic [2:0] {
        ALU_OP_NONE = 3'b000,
        ALU_OP_SUBB = 3'b001,   // subtract_file_with_borrow_op
        ALU_OP_SWAP = 3'b010,   // nibble_exchange_op
        ALU_OP_DIR = 3'b011,    // load_port_direction_op
        ALU_OP_XORI = 3'b100,   // xor_immediate_op
        ALU_OP_XORF = 3'b101    // xor_file_op
    } alu_op_type;

    // status flags
    typedef struct packed {
        logic zero;
        logic digit_carry_flag;
        logic carry;
    } alu_flags_type;

    // one instruction request
    typedef struct packed {
        alu_op_type op;
        logic dest;              // 0 working reg, 1 file reg
        logic [7:0] file_val;    // addressed file register contents
        logic [7:0] literal;     // immediate or direction select in low bits
    } alu_req_type;
endpackage
`default_nettype wire

// *** alu_core.sv ***
// Purpose: pure combinational result and flag generation
// Assumes: operands stable for the cycle
// Notes: instantiated by alu_exec
`default_nettype none
module alu_core (
    input wire alu_pkg::alu_req_type req,
    input wire logic [7:0] w_val,
    input wire alu_pkg::alu_flags_type flags_in,
    output logic [7:0] result,
    output alu_pkg::alu_flags_type flags_out
);
    logic [8:0] diff;      // 9-bit difference, bit 8 is not-borrow
    logic [4:0] low_diff;  // low nibble difference
    logic borrow_in;       // 1 when a borrow is pending

    // compute result and flags per operation
    always_comb begin
        borrow_in = ~flags_in.carry;
        diff = {1'b0, req.file_val} + {1'b0, ~w_val} + {8'h00, ~borrow_in};
        low_diff = {1'b0, req.file_val[3:0]} + {1'b0, ~w_val[3:0]} + {4'h0, ~borrow_in};
        result = 8'h00;
        flags_out = flags_in;
        unique case (req.op)
            alu_pkg::ALU_OP_SUBB: begin
                result = diff[7:0];
                flags_out.carry = diff[8];
                flags_out.digit_carry_flag = low_diff[4];
                flags_out.zero = (diff[7:0] == 8'h00);
            end
            alu_pkg::ALU_OP_SWAP: begin
                // flags untouched
                result = {req.file_val[3:0], req.file_val[7:4]};
            end
            alu_pkg::ALU_OP_XORI: begin
                result = w_val ^ req.literal;
                flags_out.zero = ((w_val ^ req.literal) == 8'h00);
            end
            alu_pkg::ALU_OP_XORF: begin
                result = w_val ^ req.file_val;
                flags_out.zero = ((w_val ^ req.file_val) == 8'h00);
            end
            default: begin
                result = w_val; // direction load and idle pass w
            end
        endcase
    end
endmodule
`default_nettype wire

// *** alu_exec_bench.sv ***
// Purpose: self-checking bench for the subtract/swap/xor/direction datapath
// Assumes: inputs driven at falling edge, outputs compared one cycle later
// Notes: reference model tracks w, flags, direction regs and file writes
`default_nettype none
module alu_exec_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0; // core clock
    logic sys_rst = 1'b1; // sync reset
    logic req_valid = 1'b0; // request strobe
    alu_pkg::alu_req_type req = '0; // request bundle
    logic [7:0] w_reg, file_wdata, dir_a, dir_b, dir_c; // design outputs
    alu_pkg::alu_flags_type flags; // design flags
    logic file_we; // write pulse
    int error_cnt = 0;
    int n_compared = 0;
    logic [31:0] seed = 32'hC24219F2; // xorshift state
    logic [7:0] m_w, m_wd, m_res; // model working reg, write data, scratch
    logic [7:0] m_dir [3]; // model direction regs
    alu_pkg::alu_flags_type m_fl; // model flags
    logic m_we; // model write pulse
    logic [8:0] diff; // full subtract with borrow out
    logic [4:0] ldiff; // low nibble subtract
    alu_exec dut (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .req(req),
        .w_reg(w_reg), .flags(flags), .file_we(file_we), .file_wdata(file_wdata),
        .port_a_direction_reg(dir_a), .port_b_direction_reg(dir_b),
        .port_c_direction_reg(dir_c));
    // clock generator
    always #5 clk = ~clk;
    // xorshift source of stimulus
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // sends a result to w or back to the file
    function automatic void route(input logic [7:0] r);
        if (req.dest) begin
            m_we = 1'b1;
            m_wd = r;
        end else m_w = r;
    endfunction
    // model state after the coming rising edge
    task automatic model_step();
        m_we = 1'b0;
        if (sys_rst) begin
            m_w = 8'h00;
            m_wd = 8'h00;
            m_fl = '0;
            m_dir = '{8'hFF, 8'hFF, 8'hFF};
        end else if (req_valid) begin
            case (req.op)
                alu_pkg::ALU_OP_SUBB: begin
                    diff = {1'b0, req.file_val} - {1'b0, m_w} - {8'h00, ~m_fl.carry};
                    ldiff = {1'b0, req.file_val[3:0]} - {1'b0, m_w[3:0]} - {4'h0, ~m_fl.carry};
                    m_fl = {diff[7:0] == 8'h00, ~ldiff[4], ~diff[8]};
                    route(diff[7:0]);
                end
                alu_pkg::ALU_OP_SWAP: route({req.file_val[3:0], req.file_val[7:4]});
                alu_pkg::ALU_OP_DIR:
                    if (req.literal[2:0] >= 3'h5) m_dir[int'(req.literal[2:0]) - 5] = m_w;
                alu_pkg::ALU_OP_XORI: begin
                    m_w = m_w ^ req.literal;
                    m_fl.zero = (m_w == 8'h00);
                end
                alu_pkg::ALU_OP_XORF: begin
                    m_res = m_w ^ req.file_val;
                    m_fl.zero = (m_res == 8'h00);
                    route(m_res);
                end
                default: ; // no change
            endcase
        end
    endtask
    // one comparison
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // compares, then drives next request and advances the model
    task automatic cycle(input logic rst, input logic vld, input alu_pkg::alu_req_type r);
        @(negedge clk);
        check("w_reg", w_reg, m_w);
        check("flags", {5'h00, flags}, {5'h00, m_fl});
        check("file_we", {7'h00, file_we}, {7'h00, m_we});
        check("file_wdata", file_wdata, m_wd);
        check("dir_a", dir_a, m_dir[0]);
        check("dir_b", dir_b, m_dir[1]);
        check("dir_c", dir_c, m_dir[2]);
        sys_rst = rst;
        req_valid = vld;
        req = r;
        model_step();
    endtask
    // builds a request
    function automatic alu_pkg::alu_req_type mk(input logic [2:0] op, input logic d,
        input logic [7:0] f, input logic [7:0] k);
        return {alu_pkg::alu_op_type'(op), d, f, k};
    endfunction
    // verdict and end of run
    task automatic report_and_stop();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // main sequence: reset, corner cases, random traffic with a mid-run reset
    initial begin
        logic [31:0] r;
        @(negedge clk);
        model_step();
        repeat (6) cycle(1'b1, 1'b0, '0);
        cycle(1'b0, 1'b1, mk(3'h4, 1'b1, 8'h00, 8'h5A)); // xor literal, dest ignored
        cycle(1'b0, 1'b1, mk(3'h4, 1'b0, 8'h00, 8'h5A)); // zero result
        cycle(1'b0, 1'b1, mk(3'h1, 1'b1, 8'h00, 8'h00)); // borrow pending, wraps
        cycle(1'b0, 1'b1, mk(3'h1, 1'b0, 8'h10, 8'h00)); // nibble borrow
        for (int s = 4; s < 8; s++) cycle(1'b0, 1'b1, mk(3'h3, 1'b0, 8'h00, 8'(s)));
        cycle(1'b0, 1'b1, mk(3'h2, 1'b0, 8'hA5, 8'h00)); // swap to w
        cycle(1'b0, 1'b1, mk(3'h5, 1'b1, 8'h5A, 8'h00)); // xor file to file
        cycle(1'b0, 1'b1, mk(3'h0, 1'b1, 8'h12, 8'h34)); // no operation
        for (int i = 0; i < 3000; i++) begin
            r = rnd();
            cycle(i inside {[1500:1501]}, r[31:29] != 3'h0,
                mk(3'(r[28:0] % 6), r[24], r[23:16], r[15:8]));
        end
        cycle(1'b0, 1'b0, '0);
        report_and_stop();
    end
endmodule
`default_nettype wire
